// file: rtl/vipu_pkg.sv
// Purpose: Shared constants and types of the vectored interrupt priority unit
// Assumes: Program memory is word addressed, one vector entry per two address units
// Notes: Register offsets are word indexes on the plain register port
package vipu_pkg;
	localparam int VEC_TRAPS = 6;
	localparam int VEC_MAX_SRC = 246;
	localparam int VEC_W = 8;
	localparam int LVL_W = 3;
	localparam logic [LVL_W-1:0] LVL_OFF = 3'h0;
	localparam int ADDR_W = 24;
	localparam logic [ADDR_W-1:0] PRIMARY_BASE = 24'h000004;
	localparam logic [ADDR_W-1:0] RESET_ADDR = 24'h000000;
	localparam int ENTRY_SHIFT = 1;
	localparam int BOOT_LIM_W = 13;
	localparam logic [BOOT_LIM_W-1:0] BOOT_MIN_PAGES = 13'h0002;
	localparam logic [BOOT_LIM_W-1:0] BOOT_ONE_PAGE = 13'h0001;
	localparam int REG_ADDR_W = 10;
	localparam int REG_DATA_W = 16;
	localparam logic [REG_ADDR_W-1:0] REG_CTRL2 = 10'h000;
	localparam logic [REG_ADDR_W-1:0] REG_STATUS = 10'h001;
	localparam logic [REG_ADDR_W-1:0] REG_PRIO_BASE = 10'h100;
	localparam int ALT_EN_BIT = 8;
	localparam int STAT_ALT_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_VEC_LSB = 8;
	localparam logic [REG_DATA_W-1:0] REG_ZERO = 16'h0000;
	typedef enum logic [1:0] {
		VIPU_IDLE,
		VIPU_FETCH,
		VIPU_WAIT,
		VIPU_REQ
	} vipu_state_t;
endpackage

// file: rtl/vipu_arbiter.sv
// Purpose: Picks the winning pending vector by trap, then user level, then vector order
// Assumes: Level zero disables a source
// Notes: Purely combinational; the top registers only the winning vector and uses winAny, winTrap and winLevel unregistered
`timescale 1ns/1ps
module vipu_arbiter #(
	parameter int NUM_SRC = 246
) (
	input wire logic [NUM_SRC-1:0] srcReq,
	input wire logic [NUM_SRC*vipu_pkg::LVL_W-1:0] srcLevel,
	input wire logic [vipu_pkg::VEC_TRAPS-1:0] trapReq,
	output logic winAny,
	output logic winTrap,
	output logic [vipu_pkg::VEC_W-1:0] winVec,
	output logic [vipu_pkg::LVL_W-1:0] winLevel
);
	logic [vipu_pkg::LVL_W-1:0] lvl;
	always_comb begin
		lvl = vipu_pkg::LVL_OFF;
		winAny = 1'b0;
		winTrap = 1'b0;
		winVec = '0;
		winLevel = vipu_pkg::LVL_OFF;
		// Walk downwards so an equal level at a lower vector takes over
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			lvl = srcLevel[i*vipu_pkg::LVL_W +: vipu_pkg::LVL_W];
			if (srcReq[i] && lvl != vipu_pkg::LVL_OFF && lvl >= winLevel) begin
				winAny = 1'b1;
				winVec = vipu_pkg::VEC_W'(i + vipu_pkg::VEC_TRAPS);
				winLevel = lvl;
			end
		end
		// Traps sit below every source in the table and ignore levels
		for (int t = vipu_pkg::VEC_TRAPS - 1; t >= 0; t--) begin
			if (trapReq[t]) begin
				winAny = 1'b1;
				winTrap = 1'b1;
				winVec = vipu_pkg::VEC_W'(t);
			end
		end
	end
endmodule

// file: rtl/vipu_top.sv
// Purpose: Vectored interrupt controller merging traps and sources into one core request
// Assumes: Program memory answers a vector read in the cycle in which memRdEn is high
// Notes: Entry latency is fixed at three cycles from decision to core request
`timescale 1ns/1ps
// Contract
// - All requests merge into one core request
// - Seven selectable levels, level arbitrated first
// - Equal level: lower vector address wins
// - Natural priority follows table position
// - Primary table starts at word 000004h
// - Six traps plus up to 246 sources
// - Each entry delivers 24-bit handler address
// - Entry and return latency are constant
// - Alternate table needs segment, fuse, enable bit
// - Alternate enabled: all vectors from it
// - Alternate base is last boot page start
// - Alternate needs boot segment of two pages
// - Both tables inherit boot segment protection
// - Reset bypasses controller, execution at zero
module vipu_top #(
	parameter int NUM_SRC = 246,
	parameter logic [23:0] PAGE_WORDS = 24'h000800
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [NUM_SRC-1:0] irqReq,
	input wire logic [vipu_pkg::VEC_TRAPS-1:0] trapReq,
	input wire logic [vipu_pkg::LVL_W-1:0] coreLevel,
	input wire logic coreAck,
	output logic intReq,
	output logic [vipu_pkg::VEC_W-1:0] vecNum,
	output logic [vipu_pkg::ADDR_W-1:0] vecHandler,
	output logic memRdEn,
	output logic [vipu_pkg::ADDR_W-1:0] memAddr,
	output logic memProtect,
	input wire logic [vipu_pkg::ADDR_W-1:0] memRdData,
	input wire logic [vipu_pkg::BOOT_LIM_W-1:0] bootSegLimit,
	input wire logic altTableDisableFuse,
	input wire logic bootSegProtect,
	input wire logic [vipu_pkg::REG_ADDR_W-1:0] regAddr,
	input wire logic [vipu_pkg::REG_DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [vipu_pkg::REG_DATA_W-1:0] regRdata
);
	if (NUM_SRC < 1 || NUM_SRC > vipu_pkg::VEC_MAX_SRC) begin : g_bad_src
		$error("NUM_SRC out of range");
	end
	if (PAGE_WORDS == '0) begin : g_bad_page
		$error("PAGE_WORDS must be nonzero");
	end

	typedef struct packed {
		vipu_pkg::vipu_state_t st;
		logic altTableEnable;
		logic [NUM_SRC-1:0][vipu_pkg::LVL_W-1:0] prio;
		logic [vipu_pkg::VEC_W-1:0] curVec;
		logic curAlt;
		logic memRdEn;
		logic [vipu_pkg::ADDR_W-1:0] memAddr;
		logic memProtect;
		logic [vipu_pkg::ADDR_W-1:0] handler;
		logic intReq;
		logic [vipu_pkg::REG_DATA_W-1:0] rdData;
	} vipu_regs_t;

	vipu_regs_t state_reg;
	vipu_regs_t state_next;

	logic winAny;
	logic winTrap;
	logic [vipu_pkg::VEC_W-1:0] winVec;
	logic [vipu_pkg::LVL_W-1:0] winLevel;
	logic altUsable;
	logic takeNow;
	logic [vipu_pkg::ADDR_W-1:0] altBase;
	logic [vipu_pkg::REG_ADDR_W-1:0] prioIdx;
	logic prioHit;

	// Word address of a table entry
	function automatic logic [vipu_pkg::ADDR_W-1:0] entryAddr(
		input logic [vipu_pkg::ADDR_W-1:0] base,
		input logic [vipu_pkg::VEC_W-1:0] vec
	);
		logic [vipu_pkg::ADDR_W-1:0] off;
		off = vipu_pkg::ADDR_W'(vec) << vipu_pkg::ENTRY_SHIFT;
		return vipu_pkg::ADDR_W'(base + off);
	endfunction

	vipu_arbiter #(
		.NUM_SRC(NUM_SRC)
	) u_arbiter (
		.srcReq(irqReq),
		.srcLevel(state_reg.prio),
		.trapReq(trapReq),
		.winAny(winAny),
		.winTrap(winTrap),
		.winVec(winVec),
		.winLevel(winLevel)
	);

	// Segment defined, fuse programmed, enable bit set, at least two pages
	assign altUsable = state_reg.altTableEnable && altTableDisableFuse
		&& (bootSegLimit >= vipu_pkg::BOOT_MIN_PAGES);
	// First word of the last boot segment page
	assign altBase = vipu_pkg::ADDR_W'(vipu_pkg::ADDR_W'(bootSegLimit - vipu_pkg::BOOT_ONE_PAGE) * PAGE_WORDS);
	// Traps pass regardless of level; sources must beat the core level
	assign takeNow = winAny && (winTrap || winLevel > coreLevel);
	assign prioIdx = vipu_pkg::REG_ADDR_W'(regAddr - vipu_pkg::REG_PRIO_BASE);
	assign prioHit = (regAddr >= vipu_pkg::REG_PRIO_BASE) && (prioIdx < vipu_pkg::REG_ADDR_W'(NUM_SRC));

	always_comb begin
		state_next = state_reg;
		state_next.memRdEn = 1'b0;
		state_next.rdData = vipu_pkg::REG_ZERO;
		if (regWr) begin
			if (regAddr == vipu_pkg::REG_CTRL2) begin
				state_next.altTableEnable = regWdata[vipu_pkg::ALT_EN_BIT];
			end else if (prioHit) begin
				state_next.prio[prioIdx] = regWdata[vipu_pkg::LVL_W-1:0];
			end
		end
		if (regRd) begin
			if (regAddr == vipu_pkg::REG_CTRL2) begin
				state_next.rdData[vipu_pkg::ALT_EN_BIT] = state_reg.altTableEnable;
			end else if (regAddr == vipu_pkg::REG_STATUS) begin
				state_next.rdData[vipu_pkg::STAT_ALT_BIT] = altUsable;
				state_next.rdData[vipu_pkg::STAT_BUSY_BIT] = (state_reg.st != vipu_pkg::VIPU_IDLE);
				state_next.rdData[vipu_pkg::STAT_VEC_LSB +: vipu_pkg::VEC_W] = state_reg.curVec;
			end else if (prioHit) begin
				state_next.rdData[vipu_pkg::LVL_W-1:0] = state_reg.prio[prioIdx];
			end
		end
		case (state_reg.st)
			vipu_pkg::VIPU_IDLE: begin
				if (takeNow) begin
					state_next.curVec = winVec;
					state_next.curAlt = altUsable;
					state_next.st = vipu_pkg::VIPU_FETCH;
				end
			end
			vipu_pkg::VIPU_FETCH: begin
				state_next.memRdEn = 1'b1;
				state_next.memProtect = bootSegProtect;
				if (state_reg.curAlt) begin
					state_next.memAddr = entryAddr(altBase, state_reg.curVec);
				end else begin
					state_next.memAddr = entryAddr(vipu_pkg::PRIMARY_BASE, state_reg.curVec);
				end
				state_next.st = vipu_pkg::VIPU_WAIT;
			end
			vipu_pkg::VIPU_WAIT: begin
				state_next.handler = memRdData;
				state_next.intReq = 1'b1;
				state_next.st = vipu_pkg::VIPU_REQ;
			end
			vipu_pkg::VIPU_REQ: begin
				if (coreAck) begin
					state_next.intReq = 1'b0;
					state_next.st = vipu_pkg::VIPU_IDLE;
				end
			end
			default: begin
				state_next.intReq = 1'b0;
				state_next.st = vipu_pkg::VIPU_IDLE;
			end
		endcase
	end

	// Reset only clears state; the core restarts at address zero on its own
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign intReq = state_reg.intReq;
	assign vecNum = state_reg.curVec;
	assign vecHandler = state_reg.handler;
	assign memRdEn = state_reg.memRdEn;
	assign memAddr = state_reg.memAddr;
	assign memProtect = state_reg.memProtect;
	assign regRdata = state_reg.rdData;

	// Shadow of the arbiter, worked out source by source for the checks below
	logic outranked;
	logic tieLost;
	logic trapLost;
	always_comb begin
		outranked = 1'b0;
		tieLost = 1'b0;
		trapLost = 1'b0;
		for (int j = 0; j < NUM_SRC; j++) begin
			if (irqReq[j] && state_reg.prio[j] > winLevel) begin
				outranked = 1'b1;
			end
			if (irqReq[j] && state_reg.prio[j] != vipu_pkg::LVL_OFF && state_reg.prio[j] == winLevel
				&& vipu_pkg::VEC_W'(j + vipu_pkg::VEC_TRAPS) < winVec) begin
				tieLost = 1'b1;
			end
		end
		for (int t = 0; t < vipu_pkg::VEC_TRAPS; t++) begin
			if (trapReq[t] && vipu_pkg::VEC_W'(t) < winVec) begin
				trapLost = 1'b1;
			end
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);

	// Entry sequence and timing
	chk_req_hold: assert property (intReq && !coreAck |=> intReq)
		else $error("request dropped before acceptance");
	chk_fixed_entry: assert property (state_reg.st == vipu_pkg::VIPU_IDLE && takeNow
		|=> !intReq ##1 memRdEn && !intReq ##1 !memRdEn && intReq)
		else $error("entry latency not three cycles");
	chk_primary_addr: assert property (memRdEn && !state_reg.curAlt
		|-> memAddr == entryAddr(vipu_pkg::PRIMARY_BASE, vecNum))
		else $error("primary entry address wrong");
	chk_alt_addr: assert property (memRdEn && state_reg.curAlt
		|-> memAddr == entryAddr($past(altBase), vecNum))
		else $error("alternate entry address wrong");
	chk_alt_gate: assert property (state_reg.st == vipu_pkg::VIPU_IDLE && takeNow
		|=> state_reg.curAlt == $past(state_reg.altTableEnable && altTableDisableFuse
		&& bootSegLimit >= vipu_pkg::BOOT_MIN_PAGES))
		else $error("alternate table choice wrong");
	chk_short_segment: assert property (memRdEn && $past(bootSegLimit, 2) < vipu_pkg::BOOT_MIN_PAGES
		&& $past(bootSegLimit) < vipu_pkg::BOOT_MIN_PAGES |-> !state_reg.curAlt)
		else $error("alternate used with short boot segment");
	chk_handler_data: assert property (memRdEn |=> intReq && vecHandler == $past(memRdData))
		else $error("handler not taken from memory");
	chk_protect: assert property (memRdEn |-> memProtect == $past(bootSegProtect))
		else $error("vector fetch lacks boot protection");
	chk_fetch_pulse: assert property (memRdEn |=> !memRdEn)
		else $error("vector fetch longer than one cycle");
	chk_fetch_issue: assert property (state_reg.st == vipu_pkg::VIPU_FETCH |=> memRdEn)
		else $error("fetch state without memory read");
	chk_vec_stable: assert property (intReq && !coreAck
		|=> $stable(vecNum) && $stable(vecHandler))
		else $error("vector changed while requested");
	chk_ack_release: assert property (intReq && coreAck
		|=> !intReq && state_reg.st == vipu_pkg::VIPU_IDLE)
		else $error("request not released after acceptance");
	chk_no_take_busy: assert property (state_reg.st == vipu_pkg::VIPU_REQ && !coreAck
		|=> state_reg.st == vipu_pkg::VIPU_REQ)
		else $error("request left before acceptance");
	chk_idle_quiet: assert property (state_reg.st == vipu_pkg::VIPU_IDLE
		|-> !intReq && !memRdEn)
		else $error("idle unit drives a request");
	chk_alt_latched: assert property (state_reg.st != vipu_pkg::VIPU_IDLE
		|=> $stable(state_reg.curAlt))
		else $error("table choice changed during entry");

	// Arbitration
	chk_trap_first: assert property (state_reg.st == vipu_pkg::VIPU_IDLE && (|trapReq)
		|=> vecNum < vipu_pkg::VEC_W'(vipu_pkg::VEC_TRAPS))
		else $error("trap lost to a source");
	chk_trap_taken: assert property (state_reg.st == vipu_pkg::VIPU_IDLE && (|trapReq)
		|=> state_reg.st == vipu_pkg::VIPU_FETCH)
		else $error("trap masked by core level");
	chk_take_above: assert property (state_reg.st == vipu_pkg::VIPU_IDLE
		&& winAny && winLevel > coreLevel |=> state_reg.st == vipu_pkg::VIPU_FETCH)
		else $error("source above core level not taken");
	chk_level_gate: assert property (state_reg.st == vipu_pkg::VIPU_IDLE && !(|trapReq)
		&& winLevel <= coreLevel |=> state_reg.st == vipu_pkg::VIPU_IDLE)
		else $error("source taken at or below core level");
	chk_decision_vec: assert property (state_reg.st == vipu_pkg::VIPU_IDLE && takeNow
		|=> vecNum == $past(winVec))
		else $error("delivered vector differs from winner");
	chk_vector_order: assert property (state_reg.st == vipu_pkg::VIPU_IDLE && !(|trapReq)
		&& irqReq[0] && state_reg.prio[0] != vipu_pkg::LVL_OFF && state_reg.prio[0] == winLevel
		|-> winVec == vipu_pkg::VEC_W'(vipu_pkg::VEC_TRAPS))
		else $error("lower vector lost at equal level");
	chk_level_first: assert property (!outranked)
		else $error("higher level source passed over");
	chk_tie_order: assert property (!tieLost)
		else $error("equal level source at lower vector passed over");
	chk_trap_order: assert property (!trapLost)
		else $error("trap lost to a later vector");
	chk_single_vec: assert property (intReq |-> vecNum < vipu_pkg::VEC_W'(vipu_pkg::VEC_TRAPS + NUM_SRC))
		else $error("vector number out of table");

	// Register port
	chk_ctrl_write: assert property (regWr && regAddr == vipu_pkg::REG_CTRL2
		|=> state_reg.altTableEnable == $past(regWdata[vipu_pkg::ALT_EN_BIT]))
		else $error("alternate enable bit not written");
	chk_ctrl_read: assert property (regRd && regAddr == vipu_pkg::REG_CTRL2
		|=> regRdata[vipu_pkg::ALT_EN_BIT] == $past(state_reg.altTableEnable))
		else $error("alternate enable bit read back wrong");
	chk_prio_write: assert property (regWr && prioHit
		|=> state_reg.prio[$past(prioIdx)] == $past(regWdata[vipu_pkg::LVL_W-1:0]))
		else $error("priority level not written");
	chk_prio_read: assert property (regRd && prioHit
		|=> regRdata == vipu_pkg::REG_DATA_W'($past(state_reg.prio[prioIdx])))
		else $error("priority level read back wrong");
	chk_status_alt: assert property (regRd && regAddr == vipu_pkg::REG_STATUS
		|=> regRdata[vipu_pkg::STAT_ALT_BIT] == $past(state_reg.altTableEnable && altTableDisableFuse
		&& bootSegLimit >= vipu_pkg::BOOT_MIN_PAGES))
		else $error("alternate usable flag wrong");
endmodule

// file: verification/vipu_core_model.sv
// Purpose: Core and program memory partner of the interrupt unit
// Assumes: A vector word is its fetch address xor a fixed mask
// Notes: The bench sets the ack delay to cover both prompt and slow cores
`timescale 1ns/1ps
module vipu_core_model (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic intReq,
	input wire logic memRdEn,
	input wire logic [23:0] memAddr,
	input wire logic [3:0] ackDly,
	output logic coreAck,
	output logic [23:0] memRdData
);
	logic [3:0] waitCnt;
	logic [23:0] fillWord;
	// Any address read while memRdEn is high is served; otherwise the filler word is driven
	assign memRdData = memRdEn ? (memAddr ^ 24'h5a5a5a) : fillWord;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			coreAck <= 1'h0;
			waitCnt <= 4'h0;
			fillWord <= 24'h0;
		end else begin
			// Filler toggles so an early or late capture shows up
			fillWord <= ~fillWord;
			if (coreAck) begin
				coreAck <= 1'h0;
				waitCnt <= 4'h0;
			end else if (intReq && waitCnt == ackDly) begin
				coreAck <= 1'h1;
			end else if (intReq) begin
				waitCnt <= waitCnt + 4'h1;
			end
		end
	end
endmodule

// file: verification/tb_vectored_interrupt_priority_unit.sv
// Purpose: Self-checking bench of the vectored interrupt priority unit
// Assumes: Core model acks requests and serves vector fetches
// Notes: Eight sources keep the priority setup short
`timescale 1ns/1ps
module tb_vectored_interrupt_priority_unit;
	localparam int NS = 8;
	logic sys_clk = 1'h0, arst_n = 1'h0, coreAck, memRdEn, memProtect, intReq;
	logic altFuse = 1'h0, bootProt = 1'h0, regWr = 1'h0, regRd = 1'h0, altEn;
	logic [NS-1:0] irqReq = '0, rq;
	logic [5:0] trapReq = 6'h0, tr;
	logic [2:0] coreLevel = 3'h0, cl;
	logic [2:0] prio [NS];
	logic [7:0] vecNum;
	logic [23:0] vecHandler, memAddr, memRdData;
	logic [12:0] bsl = 13'h0;
	logic [9:0] regAddr = 10'h0;
	logic [15:0] regWdata = 16'h0, regRdata, d;
	logic [3:0] ackDly = 4'h0;
	// Drive edge, decision, fetch, request: intReq is seen at the fourth falling edge
	localparam int LAT_EXP = 4;
	int mismatches = 0, n_checks = 0, seed = 68156, cycles = 0, lat, ev, n, fetches;
	vipu_top #(.NUM_SRC(NS)) vipu_top_inst (.sys_clk(sys_clk), .arst_n(arst_n), .irqReq(irqReq),
		.trapReq(trapReq), .coreLevel(coreLevel), .coreAck(coreAck), .intReq(intReq), .vecNum(vecNum),
		.vecHandler(vecHandler), .memRdEn(memRdEn), .memAddr(memAddr), .memProtect(memProtect),
		.memRdData(memRdData), .bootSegLimit(bsl), .altTableDisableFuse(altFuse), .bootSegProtect(bootProt),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
	vipu_core_model vipu_core_model_inst (.sys_clk(sys_clk), .arst_n(arst_n), .intReq(intReq),
		.memRdEn(memRdEn), .memAddr(memAddr), .ackDly(ackDly), .coreAck(coreAck), .memRdData(memRdData));
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			end_sim();
		end
	end
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [9:0] a, input logic [15:0] v);
		@(posedge sys_clk);
		regWr <= 1'h1;
		regAddr <= a;
		regWdata <= v;
		@(posedge sys_clk);
		regWr <= 1'h0;
	endtask
	task rd(input logic [9:0] a, output logic [15:0] v);
		@(posedge sys_clk);
		regRd <= 1'h1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 1'h0;
		@(negedge sys_clk);
		v = regRdata;
	endtask
	// Trap lowest index first, else highest level above the core, lowest index on ties
	function int winner();
		int w;
		logic [2:0] best;
		w = -1;
		best = cl;
		for (int j = NS - 1; j >= 0; j--) if (rq[j] && prio[j] > cl && prio[j] >= best) begin
			w = 6 + j;
			best = prio[j];
		end
		for (int t = 5; t >= 0; t--) if (tr[t]) w = t;
		return w;
	endfunction
	function logic [23:0] eaddr(int v);
		logic [23:0] base;
		base = (altEn && altFuse && bsl >= 13'h2) ? ({11'h0, bsl} - 24'h1) * 24'h800 : 24'h4;
		return base + 24'(2 * v);
	endfunction
	initial begin
		for (int k = 0; k < NS; k++) prio[k] = 3'h0;
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'h1;
		@(negedge sys_clk);
		chk(intReq, 32'h0);
		chk(memRdEn, 32'h0);
		wr(10'h3ff, 16'hffff);
		rd(10'h3ff, d);
		chk(d, 32'h0);
		for (int i = 0; i < 40; i++) begin
			@(posedge sys_clk);
			altEn = 1'($random(seed));
			bsl <= (i == 2) ? 13'h1 : 13'($random(seed)) & 13'h3;
			altFuse <= (i == 2) | 1'($random(seed));
			bootProt <= 1'($random(seed));
			ackDly <= 4'($random(seed));
			cl = (i == 1) ? 3'h7 : 3'($random(seed));
			coreLevel <= cl;
			wr(vipu_pkg::REG_CTRL2, {7'h0, altEn, 8'h0});
			for (int k = 0; k < NS; k++) begin
				prio[k] = (i == 0) ? 3'h4 : 3'($random(seed));
				wr(vipu_pkg::REG_PRIO_BASE + 10'(k), {13'h0, prio[k]});
			end
			rd(vipu_pkg::REG_PRIO_BASE + 10'(i % NS), d);
			chk(d, {13'h0, prio[i % NS]});
			rd(vipu_pkg::REG_STATUS, d);
			chk(d[0], altEn && altFuse && bsl >= 13'h2);
			rq = (i == 0) ? '1 : NS'($random(seed));
			tr = (i == 1) ? 6'h24 : ((($random(seed) & 7) == 0) ? 6'($random(seed)) : 6'h0);
			ev = winner();
			@(posedge sys_clk);
			irqReq <= rq;
			trapReq <= tr;
			lat = 0;
			fetches = 0;
			while (intReq !== 1'h1 && lat < 12) begin
				@(negedge sys_clk);
				lat++;
				if (memRdEn === 1'h1) fetches++;
			end
			if (ev < 0) begin
				chk(intReq, 32'h0);
				chk(fetches, 32'h0);
			end else begin
				chk(lat, LAT_EXP);
				chk(fetches, 32'h1);
				chk(vecNum, ev);
				chk(memAddr, eaddr(ev));
				chk(vecHandler, eaddr(ev) ^ 24'h5a5a5a);
				chk(memProtect, bootProt);
				n = 0;
				do begin
					chk(intReq, 32'h1);
					@(negedge sys_clk);
					n++;
				end while (coreAck !== 1'h1 && n < 20);
			end
			@(posedge sys_clk);
			irqReq <= '0;
			trapReq <= 6'h0;
			@(negedge sys_clk);
			chk(intReq, 32'h0);
		end
		end_sim();
	end
endmodule
